/* File: include/relax_tracker_map.vh */
// register map and constants of the battery relaxation state tracker
`ifndef RELAX_TRACKER_MAP_VH
`define RELAX_TRACKER_MAP_VH
`define REG_CTRL 8'h00
`define REG_IDLE_BAND 8'h04
`define REG_SETTLE 8'h08
`define REG_EXIT 8'h0C
`define REG_FLOW_THR 8'h10
`define REG_STATUS 8'h14
`define REG_LEARN 8'h18
`define REG_UPD_CNT 8'h1C
`define REG_CHG_END_V 8'h20
`define REG_LAST_CUR 8'h24
`define REG_LAST_PWR 8'h28
`define REG_SAG 8'h2C
`define REG_SAG_LIM 8'h30
`define REG_EMPTY_TGT 8'h34
`define REG_HEAT 8'h38
`define REG_IR_CAP 8'h3C
`define CTRL_LEARN_START 0
`define CTRL_GOLDEN 1
`define CTRL_CHG_TERM 2
`define CTRL_SPIKE 3
`define CTRL_WAKE_LOAD 4
`define CTRL_LEARN_OK 5
`define SETTLE_DEF_S 16'h003C
`define EXIT_DEF_S 16'h003C
`define IDLE_BAND_DEF 16'h000A
`define FLOW_THR_DEF 16'h004B
`define CHG_END_V_DEF 16'h1068
`define SAG_MIN_DEF 16'h0000
`define SAG_MAX_DEF 16'h01F4
`define OCV_WAIT_S 16'h0708
`define DRIFT_LIMIT_UV 16'h0004
`define MIN_DSG_S 16'h01F4
`define LEARN_STARTED 8'h04
`define LEARN_CHG_DONE 8'h05
`define LEARN_DSG_DONE 8'h06
`define LEARN_GOLDEN 8'h02
`define LEARN_GOLDEN_BIT 2
`define IR_CAP_DEF 16'h0064
`define TICKS_PER_S 32'd40000000
`endif

/* File: core/relax_tracker.v */
// battery relaxation state tracker with wishbone register access
`timescale 1ns/1ps
`default_nettype none
`include "relax_tracker_map.vh"
module relax_tracker #(
	parameter TICKS_PER_S = `TICKS_PER_S
) (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	input wire signed [15:0] avg_current_i,
	input wire signed [15:0] inst_current_i,
	input wire [15:0] cell_voltage_i,
	input wire [15:0] drift_uv_i,
	input wire [15:0] spike_drop_i,
	input wire [15:0] cutoff_voltage_i,
	input wire [15:0] ir_drop_i,
	output reg [1:0] op_mode_o,
	output reg ocv_sample_o,
	output reg [15:0] empty_target_o,
	output reg [15:0] ir_corr_o
);
	localparam M_CHG = 2'b00;
	localparam M_DSG = 2'b01;
	localparam M_RELAX = 2'b10;

	reg [31:0] tick_cnt_ff;
	reg sec_ff;
	reg [5:0] ctrl_ff;
	reg [15:0] band_ff, chg_settle_ff, dsg_settle_ff, exit_ff, chg_thr_ff, dsg_thr_ff;
	reg [7:0] learn_ff;
	reg [15:0] upd_cnt_ff, chg_end_v_ff, sag_ff, sag_min_ff, sag_max_ff, heat_ff, ir_cap_ff;
	reg signed [15:0] last_cur_ff;
	reg signed [31:0] last_pwr_ff;
	reg [1:0] mode_ff;
	reg [1:0] prev_zone_ff;
	reg [15:0] settle_cnt_ff, exit_cnt_ff, relax_cnt_ff, dsg_secs_ff;
	reg settling_ff, settle_from_chg_ff, ocv_done_ff;
	reg signed [47:0] cur_acc_ff;
	reg signed [63:0] pwr_acc_ff;
	reg [15:0] heat_rise_ff;

	wire in_band = (avg_current_i < $signed(band_ff)) && (avg_current_i > -$signed(band_ff));
	wire above = avg_current_i >= $signed(band_ff);
	wire below = avg_current_i <= -$signed(band_ff);
	wire [1:0] zone = above ? 2'd1 : (below ? 2'd2 : 2'd0);
	wire flow = (avg_current_i > $signed(chg_thr_ff)) || (avg_current_i < -$signed(dsg_thr_ff));
	wire bus_wr = cyc_i && stb_i && we_i && !ack_o;
	wire [15:0] settle_lim = settle_from_chg_ff ? chg_settle_ff : dsg_settle_ff;
	wire leaving_dsg = (mode_ff == M_DSG) && (above || (settling_ff && sec_ff && in_band
		&& settle_cnt_ff + 16'h0001 >= settle_lim));
	wire [15:0] sag_clamped = (spike_drop_i > sag_max_ff) ? sag_max_ff :
		((spike_drop_i < sag_min_ff) ? sag_min_ff : spike_drop_i);
	wire signed [31:0] pwr_now = inst_current_i * $signed({1'b0, cell_voltage_i});
	wire signed [47:0] cur_avg = cur_acc_ff / $signed({32'h0, dsg_secs_ff});
	wire signed [63:0] pwr_avg = pwr_acc_ff / $signed({48'h0, dsg_secs_ff});
	wire [15:0] cur_mag = inst_current_i[15] ? -inst_current_i : inst_current_i;
	wire [31:0] heat_prod = heat_ff * cur_mag;

	////////////////////////////////////////////////////////////////////////////
	// one-second tick
	always @(posedge clk_i) begin
		if (rst_i || tick_cnt_ff == TICKS_PER_S - 1) begin
			tick_cnt_ff <= 32'h0000_0000;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
		end
		sec_ff <= !rst_i && (tick_cnt_ff == TICKS_PER_S - 1);
	end

	////////////////////////////////////////////////////////////////////////////
	// mode tracking
	always @(posedge clk_i) begin
		if (rst_i) begin
			mode_ff <= M_RELAX;
			prev_zone_ff <= 2'd0;
			settle_cnt_ff <= 16'h0000;
			exit_cnt_ff <= 16'h0000;
			relax_cnt_ff <= 16'h0000;
			settling_ff <= 1'b0;
			settle_from_chg_ff <= 1'b0;
			ocv_done_ff <= 1'b0;
			ocv_sample_o <= 1'b0;
		end else begin
			prev_zone_ff <= zone;
			ocv_sample_o <= 1'b0;
			if (mode_ff == M_RELAX) begin
				settling_ff <= 1'b0;
				// exit needs flow held for the full delay; short pulses keep us relaxed
				if (!flow) begin
					exit_cnt_ff <= 16'h0000;
				end else if (sec_ff) begin
					if (exit_cnt_ff + 16'h0001 >= exit_ff) begin
						mode_ff <= (avg_current_i > 0) ? M_CHG : M_DSG;
						exit_cnt_ff <= 16'h0000;
						relax_cnt_ff <= 16'h0000;
						ocv_done_ff <= 1'b0;
					end else begin
						exit_cnt_ff <= exit_cnt_ff + 16'h0001;
					end
				end
				if (sec_ff && relax_cnt_ff < `OCV_WAIT_S) begin
					relax_cnt_ff <= relax_cnt_ff + 16'h0001;
				end
				if (relax_cnt_ff >= `OCV_WAIT_S && !ocv_done_ff && drift_uv_i < `DRIFT_LIMIT_UV) begin
					ocv_sample_o <= 1'b1;
					ocv_done_ff <= 1'b1;
				end
			end else begin
				if (mode_ff == M_CHG && below) begin
					mode_ff <= M_DSG;
				end else if (mode_ff == M_DSG && above) begin
					mode_ff <= M_CHG;
				end
				if (in_band && prev_zone_ff != 2'd0) begin
					settling_ff <= 1'b1;
					settle_cnt_ff <= 16'h0000;
					settle_from_chg_ff <= (prev_zone_ff == 2'd1);
				end else if (!in_band) begin
					settling_ff <= 1'b0;
					settle_cnt_ff <= 16'h0000;
				end else if (settling_ff && sec_ff) begin
					if (settle_cnt_ff + 16'h0001 >= settle_lim) begin
						mode_ff <= M_RELAX;
						settling_ff <= 1'b0;
						relax_cnt_ff <= 16'h0000;
						exit_cnt_ff <= 16'h0000;
					end else begin
						settle_cnt_ff <= settle_cnt_ff + 16'h0001;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// discharge averaging and last-run capture
	always @(posedge clk_i) begin
		if (rst_i) begin
			cur_acc_ff <= 48'sh0;
			pwr_acc_ff <= 64'sh0;
			dsg_secs_ff <= 16'h0000;
			last_cur_ff <= 16'sh0;
			last_pwr_ff <= 32'sh0;
		end else if (mode_ff != M_DSG) begin
			cur_acc_ff <= 48'sh0;
			pwr_acc_ff <= 64'sh0;
			dsg_secs_ff <= 16'h0000;
		end else if (leaving_dsg) begin
			if (dsg_secs_ff >= `MIN_DSG_S) begin
				last_cur_ff <= cur_avg[15:0];
				last_pwr_ff <= pwr_avg[31:0];
			end
		end else if (sec_ff) begin
			cur_acc_ff <= cur_acc_ff + avg_current_i;
			pwr_acc_ff <= pwr_acc_ff + pwr_now;
			if (dsg_secs_ff != 16'hFFFF) begin
				dsg_secs_ff <= dsg_secs_ff + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// learning, capacity model values and register writes
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= 6'h00;
			band_ff <= `IDLE_BAND_DEF;
			chg_settle_ff <= `SETTLE_DEF_S;
			dsg_settle_ff <= `SETTLE_DEF_S;
			exit_ff <= `EXIT_DEF_S;
			chg_thr_ff <= `FLOW_THR_DEF;
			dsg_thr_ff <= `FLOW_THR_DEF;
			learn_ff <= 8'h00;
			upd_cnt_ff <= 16'h0000;
			chg_end_v_ff <= `CHG_END_V_DEF;
			sag_ff <= `SAG_MIN_DEF;
			sag_min_ff <= `SAG_MIN_DEF;
			sag_max_ff <= `SAG_MAX_DEF;
			heat_ff <= 16'h0000;
			ir_cap_ff <= `IR_CAP_DEF;
		end else begin
			ctrl_ff <= 6'h00;
			if (bus_wr) begin
				case (adr_i)
				`REG_CTRL: ctrl_ff <= dat_i[5:0];
				`REG_IDLE_BAND: band_ff <= dat_i[15:0];
				`REG_SETTLE: begin
					chg_settle_ff <= dat_i[15:0];
					dsg_settle_ff <= dat_i[31:16];
				end
				`REG_EXIT: exit_ff <= dat_i[15:0];
				`REG_FLOW_THR: begin
					chg_thr_ff <= dat_i[15:0];
					dsg_thr_ff <= dat_i[31:16];
				end
				`REG_CHG_END_V: chg_end_v_ff <= dat_i[15:0];
				`REG_SAG: sag_ff <= dat_i[15:0];
				`REG_SAG_LIM: begin
					sag_min_ff <= dat_i[15:0];
					sag_max_ff <= dat_i[31:16];
				end
				`REG_HEAT: heat_ff <= dat_i[15:0];
				`REG_IR_CAP: ir_cap_ff <= dat_i[15:0];
				default: ;
				endcase
			end
			if (ctrl_ff[`CTRL_LEARN_START] && learn_ff == 8'h00) begin
				learn_ff <= `LEARN_STARTED;
			end else if (ctrl_ff[`CTRL_GOLDEN] && learn_ff == `LEARN_DSG_DONE) begin
				learn_ff[`LEARN_GOLDEN_BIT] <= 1'b0;
			end else if (ocv_sample_o && learn_ff == `LEARN_STARTED && !settle_from_chg_ff) begin
				learn_ff <= `LEARN_STARTED; // waits for a relax that followed charge
			end else if (ocv_sample_o && learn_ff == `LEARN_STARTED) begin
				learn_ff <= `LEARN_CHG_DONE;
			end else if (ocv_sample_o && learn_ff == `LEARN_CHG_DONE && ctrl_ff[`CTRL_LEARN_OK] == 1'b0
				&& !settle_from_chg_ff) begin
				learn_ff <= `LEARN_DSG_DONE;
			end
			if (ocv_sample_o && upd_cnt_ff != 16'hFFFF) begin
				upd_cnt_ff <= upd_cnt_ff + 16'h0001;
			end
			if (ctrl_ff[`CTRL_CHG_TERM]) begin
				chg_end_v_ff <= cell_voltage_i;
			end
			if (ctrl_ff[`CTRL_SPIKE] && sag_clamped > sag_ff) begin
				sag_ff <= sag_clamped;
			end else if (sag_ff > sag_max_ff) begin
				sag_ff <= sag_max_ff;
			end else if (sag_ff < sag_min_ff) begin
				sag_ff <= sag_min_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs and bus answer
	always @(posedge clk_i) begin
		if (rst_i) begin
			op_mode_o <= M_RELAX;
			empty_target_o <= 16'h0000;
			ir_corr_o <= 16'h0000;
			heat_rise_ff <= 16'h0000;
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			op_mode_o <= mode_ff;
			empty_target_o <= cutoff_voltage_i + sag_ff;
			if (ctrl_ff[`CTRL_WAKE_LOAD]) begin
				ir_corr_o <= (ir_drop_i > ir_cap_ff) ? ir_cap_ff : ir_drop_i;
			end
			// zero factor means no self-heating term at all
			heat_rise_ff <= heat_prod[25:10];
			ack_o <= cyc_i && stb_i && !ack_o;
			case (adr_i)
			`REG_IDLE_BAND: dat_o <= {16'h0000, band_ff};
			`REG_SETTLE: dat_o <= {dsg_settle_ff, chg_settle_ff};
			`REG_EXIT: dat_o <= {16'h0000, exit_ff};
			`REG_FLOW_THR: dat_o <= {dsg_thr_ff, chg_thr_ff};
			`REG_STATUS: dat_o <= {heat_rise_ff, 11'h000, ocv_done_ff, settling_ff, settle_from_chg_ff, mode_ff};
			`REG_LEARN: dat_o <= {24'h000000, learn_ff};
			`REG_UPD_CNT: dat_o <= {16'h0000, upd_cnt_ff};
			`REG_CHG_END_V: dat_o <= {16'h0000, chg_end_v_ff};
			`REG_LAST_CUR: dat_o <= {{16{last_cur_ff[15]}}, last_cur_ff};
			`REG_LAST_PWR: dat_o <= last_pwr_ff;
			`REG_SAG: dat_o <= {16'h0000, sag_ff};
			`REG_SAG_LIM: dat_o <= {sag_max_ff, sag_min_ff};
			`REG_EMPTY_TGT: dat_o <= {16'h0000, empty_target_o};
			`REG_HEAT: dat_o <= {16'h0000, heat_ff};
			`REG_IR_CAP: dat_o <= {16'h0000, ir_cap_ff};
			default: dat_o <= 32'h0000_0000;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: verification/relax_tracker_asserts.sv */
// port assertions for the relaxation tracker
`timescale 1ns/1ps
`default_nettype none
module relax_tracker_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic signed [15:0] avg_current_i,
	input wire logic [15:0] drift_uv_i,
	input wire logic [15:0] cutoff_voltage_i,
	input wire logic [1:0] op_mode_o,
	input wire logic ocv_sample_o,
	input wire logic [15:0] empty_target_o,
	input wire logic [15:0] ir_corr_o
);
	// band and flow limits are the reset defaults; the bench never rewrites them
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_relax_in;
		op_mode_o == 2'd2 && $past(op_mode_o) != 2'd2;
	endsequence
	property p_ack_after_req;
		s_req |=> ack_o;
	endproperty
	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	property p_relax_entry;
		s_relax_in |-> $past(avg_current_i) >= 16'shFFF6 && $past(avg_current_i) <= 16'sh000A;
	endproperty
	property p_exit_chg;
		op_mode_o == 2'd0 && $past(op_mode_o) == 2'd2 |-> $past(avg_current_i) > 16'sh004B
			&& $past(avg_current_i, 2) > 16'sh004B;
	endproperty
	property p_exit_dsg;
		op_mode_o == 2'd1 && $past(op_mode_o) == 2'd2 |-> $past(avg_current_i) < 16'shFFB5
			&& $past(avg_current_i, 2) < 16'shFFB5;
	endproperty
	property p_ocv;
		ocv_sample_o |-> op_mode_o == 2'd2 && $past(drift_uv_i) < 16'h0004;
	endproperty
	property p_ocv_once;
		ocv_sample_o |=> !ocv_sample_o [*8];
	endproperty
	property p_target;
		(!rst_i && $stable(cutoff_voltage_i)) [*2] |-> empty_target_o >= cutoff_voltage_i;
	endproperty
	property p_ir_cap;
		ir_corr_o <= 16'h0064;
	endproperty
	////////////////////////////////////////////////////////////////
	a_ack_after_req: assert property (p_ack_after_req) else $error("request not acked next cycle");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	a_relax_entry: assert property (p_relax_entry) else $error("relax entered outside idle band");
	a_exit_chg: assert property (p_exit_chg) else $error("charge entered without flow");
	a_exit_dsg: assert property (p_exit_dsg) else $error("discharge entered without flow");
	a_ocv: assert property (p_ocv) else $error("sample outside relax or drift high");
	a_ocv_once: assert property (p_ocv_once) else $error("sample repeated");
	a_target: assert property (p_target) else $error("empty target below cutoff");
	a_ir_cap: assert property (p_ir_cap) else $error("correction above cap");
endmodule
bind relax_tracker relax_tracker_asserts relax_tracker_asserts_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .ack_o(ack_o), .avg_current_i(avg_current_i), .drift_uv_i(drift_uv_i),
	.cutoff_voltage_i(cutoff_voltage_i), .op_mode_o(op_mode_o), .ocv_sample_o(ocv_sample_o),
	.empty_target_o(empty_target_o), .ir_corr_o(ir_corr_o));
`default_nettype wire

/* File: verification/relax_tracker_tb.sv */
// self-checking bench for the relaxation tracker
`timescale 1ns/1ps
`default_nettype none
`include "relax_tracker_map.vh"
module relax_tracker_tb;
	// four ticks a second keeps the 1800 s wait short
	localparam int T = 4;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, ocv_o;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0000_0000, dat_o, q, prev;
	logic signed [15:0] avg = 16'sh0000, inst = 16'sh0000;
	logic [15:0] volt = 16'h0E74, drift = 16'h000A, spike = 16'h0000, cutoff = 16'h0BB8, irdrop = 16'h0000;
	logic [15:0] tgt_o, irc_o;
	logic [1:0] mode_o;
	int miscompares = 0, n_tests = 0, ocv_n = 0;
	localparam logic [72:0] ROWS [13] = '{
		{1'b0, `REG_CHG_END_V, 32'h0000_0000, 32'h0000_1068},
		{1'b0, `REG_SETTLE, 32'h0000_0000, 32'h003C_003C},
		{1'b0, `REG_EXIT, 32'h0000_0000, 32'h0000_003C},
		{1'b0, `REG_FLOW_THR, 32'h0000_0000, 32'h004B_004B},
		{1'b0, `REG_IDLE_BAND, 32'h0000_0000, 32'h0000_000A},
		{1'b0, `REG_LEARN, 32'h0000_0000, 32'h0000_0000},
		{1'b0, `REG_UPD_CNT, 32'h0000_0000, 32'h0000_0000},
		{1'b0, `REG_IR_CAP, 32'h0000_0000, 32'h0000_0064},
		{1'b0, `REG_SAG_LIM, 32'h0000_0000, 32'h01F4_0000},
		{1'b1, 8'h44, 32'hDEAD_BEEF, 32'h0000_0000},
		{1'b0, 8'h44, 32'h0000_0000, 32'h0000_0000},
		{1'b1, `REG_HEAT, 32'h0000_0005, 32'h0000_0000},
		{1'b0, `REG_HEAT, 32'h0000_0000, 32'h0000_0005}};
	localparam logic [47:0] SAG [3] = '{{16'h0032, 16'h0032, 16'h0BEA}, {16'h0320, 16'h01F4, 16'h0DAC},
		{16'h0014, 16'h01F4, 16'h0DAC}};
	relax_tracker #(.TICKS_PER_S(T)) relax_tracker_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.avg_current_i(avg), .inst_current_i(inst), .cell_voltage_i(volt), .drift_uv_i(drift),
		.spike_drop_i(spike), .cutoff_voltage_i(cutoff), .ir_drop_i(irdrop), .op_mode_o(mode_o),
		.ocv_sample_o(ocv_o), .empty_target_o(tgt_o), .ir_corr_o(irc_o));
	initial forever #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) if (ocv_o === 1'b1) ocv_n <= ocv_n + 1;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// holds the request until ack is sampled high, then releases
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		chk({31'h0, n < 20}, 32'h0000_0001);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask
	task automatic secs(input int s);
		repeat (s * T) @(posedge clk_i);
	endtask
	task automatic wait_mode(input logic [1:0] m, input int s);
		int n;
		n = 0;
		while (mode_o !== m && n < s * T) begin
			@(posedge clk_i);
			n++;
		end
		chk({30'h0, mode_o}, {30'h0, m});
	endtask
	task automatic wait_ocv(input int s);
		int n, c;
		n = 0;
		c = ocv_n;
		while (ocv_n == c && n < s * T) begin
			@(posedge clk_i);
			n++;
		end
		chk(32'(ocv_n - c), 32'h0000_0001);
	endtask
	task automatic print_verdict;
		if (miscompares == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (40000) @(posedge clk_i);
		miscompares++;
		print_verdict;
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ROWS[i]) begin
			if (ROWS[i][72])
				wb(1'b1, ROWS[i][71:64], ROWS[i][63:32]);
			else
				rd(ROWS[i][71:64], ROWS[i][31:0]);
		end
		wb(1'b1, `REG_CTRL, 32'h0000_0001);
		rd(`REG_LEARN, 32'h0000_0004);
		avg <= 16'sh00C8;
		secs(30);
		chk({30'h0, mode_o}, 32'h0000_0002);
		wait_mode(2'd0, 40);
		volt <= 16'h1036;
		wb(1'b1, `REG_CTRL, 32'h0000_0004);
		rd(`REG_CHG_END_V, 32'h0000_1036);
		avg <= 16'sh0000;
		secs(30);
		chk({30'h0, mode_o}, 32'h0000_0000);
		wait_mode(2'd2, 40);
		drift <= 16'h0002;
		secs(1700);
		chk(32'(ocv_n), 32'h0000_0000);
		wait_ocv(200);
		rd(`REG_LEARN, 32'h0000_0005);
		rd(`REG_UPD_CNT, 32'h0000_0001);
		avg <= 16'shFF38;
		inst <= 16'shFF38;
		volt <= 16'h0E74;
		wait_mode(2'd1, 70);
		secs(600);
		rd(`REG_LAST_CUR, 32'h0000_0000);
		avg <= 16'shFFFB;
		wait_mode(2'd2, 70);
		// current and voltage stay fixed over the run, so the mean power is their product
		rd(`REG_LAST_PWR, 32'hFFF4_B560);
		wb(1'b0, `REG_LAST_CUR, 32'h0000_0000);
		prev = q;
		chk({31'h0, $signed(q[15:0]) <= 16'shFFFB && $signed(q[15:0]) >= 16'shFF38}, 32'h0000_0001);
		wait_ocv(1900);
		rd(`REG_LEARN, 32'h0000_0006);
		rd(`REG_UPD_CNT, 32'h0000_0002);
		// too short to count as a logged discharge
		avg <= 16'shFF9C;
		wait_mode(2'd1, 70);
		secs(100);
		avg <= 16'sh0000;
		wait_mode(2'd2, 70);
		rd(`REG_LAST_CUR, prev);
		wb(1'b1, `REG_CTRL, 32'h0000_0002);
		rd(`REG_LEARN, 32'h0000_0002);
		irdrop <= 16'h012C;
		wb(1'b1, `REG_CTRL, 32'h0000_0010);
		secs(1);
		chk({16'h0, irc_o}, 32'h0000_0064);
		irdrop <= 16'h0028;
		wb(1'b1, `REG_CTRL, 32'h0000_0010);
		secs(1);
		chk({16'h0, irc_o}, 32'h0000_0028);
		foreach (SAG[i]) begin
			spike <= SAG[i][47:32];
			wb(1'b1, `REG_CTRL, 32'h0000_0008);
			rd(`REG_SAG, {16'h0, SAG[i][31:16]});
			chk({16'h0, tgt_o}, {16'h0, SAG[i][15:0]});
		end
		// a gap in the flow restarts the exit delay
		avg <= 16'sh00C8;
		secs(30);
		avg <= 16'sh0000;
		secs(1);
		avg <= 16'sh00C8;
		secs(40);
		chk({30'h0, mode_o}, 32'h0000_0002);
		avg <= 16'sh0000;
		inst <= 16'sh1000;
		wb(1'b0, `REG_STATUS, 32'h0000_0000);
		prev = q;
		wb(1'b1, `REG_HEAT, 32'h0000_000A);
		wb(1'b0, `REG_STATUS, 32'h0000_0000);
		chk({31'h0, q[31:16] > prev[31:16]}, 32'h0000_0001);
		wb(1'b1, `REG_HEAT, 32'h0000_0000);
		rd(`REG_STATUS, 32'h0000_0002);
		print_verdict;
	end
endmodule
`default_nettype wire
